// file: rtl/spbsc_pkg.sv
/*
 Shared constants and state codes of the split-port burst-of-four memory core.
 Assumes a single REF_CLK domain that oversamples every pin of the memory.
*/
package spbsc_pkg;
	localparam int DATA_W = 18;
	localparam int LANE_W = 9;
	localparam int LANES = 2;
	localparam int BURST_LEN = 4;
	localparam int BEAT_W = 2;
	localparam int ADDR_W = 18;
	localparam int IMP_PERIOD = 1024;
	localparam int IMP_CNT_W = 10;
	localparam int STRAP_WAIT = 3;
	localparam logic [1:0] STRAP_WAIT_CNT = 2'h3;
	localparam logic [IMP_CNT_W-1:0] IMP_LAST = 10'h3FF;
	localparam logic [DATA_W-1:0] Q_RST = 18'h00000;
	localparam logic [BEAT_W-1:0] BEAT_RST = 2'h0;

	typedef enum logic [4:0] {
		SPBSC_W_IDLE = 5'h01,
		SPBSC_W_ODD1 = 5'h02,
		SPBSC_W_EVEN2 = 5'h04,
		SPBSC_W_ODD3 = 5'h08,
		SPBSC_W_COMMIT = 5'h10
	} spbsc_wr_state_t;
endpackage

// file: rtl/spbsc_sync.sv
/*
 Two-flop synchroniser for a bundle of pin inputs.
 Assumes each bit is a level that may change at any time relative to the clock.
*/
`timescale 1ns/100ps
module spbsc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// file: rtl/spbsc_core.sv
/*
 Split-port burst-of-four static memory core: read and write ports sharing one
 address bus, DDR data, byte-lane writes, forwarding, arbitration, strap mode.
 Assumes REF_CLK is much faster than the memory clocks so every pin edge is seen.
*/
`timescale 1ns/100ps
module spbsc_core
	import spbsc_pkg::*;
#(
	parameter int AW = spbsc_pkg::ADDR_W
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	// Memory clocks from the pins
	input wire logic IN_CLK,
	input wire logic IN_CLK_N,
	input wire logic OUT_CLK,
	input wire logic OUT_CLK_N,
	// Port selects and byte lanes
	input wire logic READ_PORT_SELECT_N,
	input wire logic WRITE_PORT_SELECT_N,
	input wire logic [spbsc_pkg::LANES-1:0] BYTE_LANE_WRITE_SELECT_N,
	// Shared address and write data
	input wire logic [AW-1:0] ADDR,
	input wire logic [spbsc_pkg::DATA_W-1:0] WR_DATA,
	// Read data
	output logic [spbsc_pkg::DATA_W-1:0] RD_DATA,
	output logic RD_DATA_OE,
	// Impedance tracking and strap mode
	output logic IMPEDANCE_UPDATE,
	output logic SINGLE_CLOCK_MODE
);
	import spbsc_pkg::*;

	localparam int SYW = 6 + LANES + AW + DATA_W;

	logic [SYW-1:0] pin_s;
	logic k_s, kn_s, c_s, cn_s, rsel_n_s, wsel_n_s;
	logic [LANES-1:0] lane_n_s;
	logic [AW-1:0] addr_s;
	logic [DATA_W-1:0] d_s;
	logic k_prev_r, kn_prev_r, c_prev_r, cn_prev_r;
	logic k_rise, kn_rise, c_rise, cn_rise, k_rise_d_r, kn_rise_d_r;
	logic oc_pos, oc_neg;
	logic single_r, strap_done_r;
	logic [1:0] strap_cnt_r;
	logic last_rd_r, last_wr_r, rd_go, wr_go;
	logic rd_pend_r, wr_pend_r;
	logic [AW-1:0] raddr_r, waddr_r, oaddr_r, wbuf_addr_r;
	logic ostage_valid_r;
	logic [BEAT_W-1:0] beat_r;
	spbsc_wr_state_t wr_state_r;
	logic [DATA_W-1:0] wd_r [BURST_LEN];
	logic [LANES-1:0] wm_r [BURST_LEN];
	logic wbuf_live_r;
	logic [IMP_CNT_W-1:0] imp_cnt_r;
	logic [DATA_W-1:0] mem [2**(AW+BEAT_W)];

	// Selects rest high so the ports come up deselected
	spbsc_sync #(
		.WIDTH(SYW),
		.RST_VAL({2'h0, 2'h3, 2'h3, {LANES{1'h1}}, {AW{1'h0}}, {DATA_W{1'h0}}})
	) u_pin_sync (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.d({IN_CLK, IN_CLK_N, OUT_CLK, OUT_CLK_N, READ_PORT_SELECT_N, WRITE_PORT_SELECT_N,
			BYTE_LANE_WRITE_SELECT_N, ADDR, WR_DATA}),
		.q(pin_s)
	);

	assign {k_s, kn_s, c_s, cn_s, rsel_n_s, wsel_n_s, lane_n_s, addr_s, d_s} = pin_s;

	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			k_prev_r <= 1'b0;
			kn_prev_r <= 1'b0;
			c_prev_r <= 1'b0;
			cn_prev_r <= 1'b0;
			k_rise_d_r <= 1'b0;
			kn_rise_d_r <= 1'b0;
		end else begin
			k_prev_r <= k_s;
			kn_prev_r <= kn_s;
			c_prev_r <= c_s;
			cn_prev_r <= cn_s;
			k_rise_d_r <= k_rise;
			kn_rise_d_r <= kn_rise;
		end
	end

	assign k_rise = k_s & ~k_prev_r;
	assign kn_rise = kn_s & ~kn_prev_r;
	// Output clocks held high give no rise, so strapped mode never sees them
	assign c_rise = c_s & ~c_prev_r & strap_done_r;
	assign cn_rise = cn_s & ~cn_prev_r & strap_done_r;

	// Delayed input edges keep staging ahead of the first output beat
	assign oc_pos = single_r ? k_rise_d_r : c_rise;
	assign oc_neg = single_r ? kn_rise_d_r : cn_rise;

	// Strap caught once, after the synchroniser has filled
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			strap_cnt_r <= 2'h0;
			strap_done_r <= 1'b0;
			single_r <= 1'b0;
		end else if (!strap_done_r) begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			if (strap_cnt_r == STRAP_WAIT_CNT) begin
				strap_done_r <= 1'b1;
				single_r <= c_s & cn_s;
			end
		end
	end

	assign SINGLE_CLOCK_MODE = single_r;

	// Port acceptance and arbitration
	assign rd_go = k_rise & strap_done_r & ~rsel_n_s & ~last_rd_r;
	assign wr_go = k_rise & strap_done_r & ~wsel_n_s & ~last_wr_r & ~rd_go;

	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			last_rd_r <= 1'b0;
			last_wr_r <= 1'b0;
			rd_pend_r <= 1'b0;
			wr_pend_r <= 1'b0;
			raddr_r <= '0;
			waddr_r <= '0;
		end else if (k_rise) begin
			last_rd_r <= rd_go;
			last_wr_r <= wr_go;
			rd_pend_r <= rd_go;
			wr_pend_r <= wr_go;
			if (rd_go) begin
				raddr_r <= addr_s;
			end
			if (wr_go) begin
				waddr_r <= addr_s;
			end
		end
	end

	// Newest word for read beat w: stored data overlaid by captured write lanes
	function automatic logic [DATA_W-1:0] fetch(input logic [BEAT_W-1:0] w);
		logic [DATA_W-1:0] v;
		v = mem[{oaddr_r, w}];
		if (wbuf_live_r && wbuf_addr_r == oaddr_r) begin
			for (int l = 0; l < LANES; l++) begin
				if (wm_r[w][l]) begin
					v[l*LANE_W +: LANE_W] = wd_r[w][l*LANE_W +: LANE_W];
				end
			end
		end
		return v;
	endfunction

	// Read output stage
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ostage_valid_r <= 1'b0;
			oaddr_r <= '0;
			beat_r <= BEAT_RST;
			RD_DATA <= Q_RST;
			RD_DATA_OE <= 1'b0;
		end else begin
			if (k_rise && rd_pend_r) begin
				ostage_valid_r <= 1'b1;
				oaddr_r <= raddr_r;
				beat_r <= BEAT_RST;
			end else if (oc_neg && ostage_valid_r && beat_r[0]) begin
				RD_DATA <= fetch(beat_r);
				RD_DATA_OE <= 1'b1;
				beat_r <= beat_r + 2'h1;
				if (beat_r == 2'h3) begin
					ostage_valid_r <= 1'b0;
				end
			end else if (oc_pos) begin
				if (ostage_valid_r && !beat_r[0]) begin
					RD_DATA <= fetch(beat_r);
					RD_DATA_OE <= 1'b1;
					beat_r <= beat_r + 2'h1;
				end else begin
					RD_DATA_OE <= 1'b0;
				end
			end
		end
	end

	// Write capture; data pins only looked at inside a burst
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wr_state_r <= SPBSC_W_IDLE;
			wbuf_live_r <= 1'b0;
			wbuf_addr_r <= '0;
			for (int i = 0; i < BURST_LEN; i++) begin
				wd_r[i] <= Q_RST;
				wm_r[i] <= '0;
			end
		end else begin
			case (wr_state_r)
				SPBSC_W_IDLE, SPBSC_W_COMMIT: begin
					if (wr_state_r == SPBSC_W_COMMIT) begin
						wbuf_live_r <= 1'b0;
					end
					if (k_rise && wr_pend_r) begin
						wd_r[0] <= d_s;
						wm_r[0] <= ~lane_n_s;
						for (int i = 1; i < BURST_LEN; i++) begin
							wm_r[i] <= '0;
						end
						wbuf_addr_r <= waddr_r;
						wbuf_live_r <= 1'b1;
						wr_state_r <= SPBSC_W_ODD1;
					end else begin
						wr_state_r <= SPBSC_W_IDLE;
					end
				end
				SPBSC_W_ODD1: begin
					if (kn_rise) begin
						wd_r[1] <= d_s;
						wm_r[1] <= ~lane_n_s;
						wr_state_r <= SPBSC_W_EVEN2;
					end
				end
				SPBSC_W_EVEN2: begin
					if (k_rise) begin
						wd_r[2] <= d_s;
						wm_r[2] <= ~lane_n_s;
						wr_state_r <= SPBSC_W_ODD3;
					end
				end
				SPBSC_W_ODD3: begin
					if (kn_rise) begin
						wd_r[3] <= d_s;
						wm_r[3] <= ~lane_n_s;
						wr_state_r <= SPBSC_W_COMMIT;
					end
				end
				default: begin
					wr_state_r <= SPBSC_W_IDLE;
				end
			endcase
		end
	end

	// Commit the selected lanes of all four words at once; no reset on the array itself
	always_ff @(posedge REF_CLK) begin
		if (wr_state_r == SPBSC_W_COMMIT) begin
			for (int i = 0; i < BURST_LEN; i++) begin
				for (int l = 0; l < LANES; l++) begin
					if (wm_r[i][l]) begin
						mem[{wbuf_addr_r, i[BEAT_W-1:0]}][l*LANE_W +: LANE_W] <= wd_r[i][l*LANE_W +: LANE_W];
					end
				end
			end
		end
	end

	// Impedance re-evaluation tick, free running on REF_CLK
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			imp_cnt_r <= '0;
			IMPEDANCE_UPDATE <= 1'b0;
		end else begin
			imp_cnt_r <= imp_cnt_r + 10'h001;
			IMPEDANCE_UPDATE <= (imp_cnt_r == IMP_LAST);
		end
	end

	a_read_spacing: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		k_rise && last_rd_r |-> !rd_go)
		else $error("read accepted on consecutive input rises");
	a_write_spacing: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		k_rise && last_wr_r |-> !wr_go)
		else $error("write accepted on consecutive input rises");
	a_arb_write: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		k_rise && last_rd_r && !rsel_n_s && !wsel_n_s |-> wr_go && !rd_go)
		else $error("write lost arbitration after a read");
	a_arb_read: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		k_rise && strap_done_r && !last_rd_r && !rsel_n_s && !wsel_n_s |-> rd_go && !wr_go)
		else $error("read lost arbitration after idle or write");
	a_read_stage: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		k_rise && rd_pend_r |=> ostage_valid_r && beat_r == 2'h0 && oaddr_r == $past(raddr_r))
		else $error("read burst not staged at next input rise");
	a_beat_drive: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		oc_pos && !k_rise && ostage_valid_r && beat_r == 2'h0 |=> RD_DATA_OE && beat_r == 2'h1)
		else $error("first read word not driven");
	a_idle_float: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		oc_pos && !k_rise && !ostage_valid_r |=> !RD_DATA_OE)
		else $error("read outputs still driven when idle");
	a_write_order: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		wr_state_r == SPBSC_W_ODD3 && kn_rise |=> wr_state_r == SPBSC_W_COMMIT ##1 (!wbuf_live_r || wr_state_r == SPBSC_W_ODD1))
		else $error("write burst did not commit after fourth word");
	a_write_ignore: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		wr_state_r == SPBSC_W_IDLE && !(k_rise && wr_pend_r) |=> wr_state_r == SPBSC_W_IDLE)
		else $error("write capture started without accepted write");
	a_strap_fixed: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		strap_done_r |=> $stable(single_r) && strap_done_r)
		else $error("clock mode strap changed during operation");
	a_imp_tick: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		IMPEDANCE_UPDATE |=> !IMPEDANCE_UPDATE [*8])
		else $error("impedance update ticks too close");
	a_sel_kstrobe: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		!k_rise |=> $stable(last_rd_r) && $stable(last_wr_r))
		else $error("port selects acted on outside an input rise");
	a_reset_float: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		!strap_done_r |-> !RD_DATA_OE)
		else $error("read outputs driven before start-up finished");
	a_word1_capture: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		wr_state_r == SPBSC_W_ODD1 && kn_rise |=> wr_state_r == SPBSC_W_EVEN2 && wd_r[1] == $past(d_s))
		else $error("second write word not captured at negative rise");
	a_lane_mask: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		wr_state_r == SPBSC_W_EVEN2 && k_rise |=> wm_r[2] == ~$past(lane_n_s))
		else $error("lane selects not sampled with third write word");
	a_commit_addr: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		wr_go |=> waddr_r == $past(addr_s))
		else $error("write address not latched at write start");
endmodule

// file: dv/spbsc_clkgen.sv
/*
 Controller-side clock source: input and output memory clock pairs.
 Assumes REF_CLK falling edges; strap input holds both output clocks high.
*/
`timescale 1ns/100ps
module spbsc_clkgen (
	// Clock and strap
	input wire logic ref_clk,
	input wire logic single,
	// Memory clocks and phase count
	output logic in_clk,
	output logic in_clk_n,
	output logic out_clk,
	output logic out_clk_n,
	output logic [2:0] phase
);
	// Eight REF_CLK per memory cycle keeps each phase above three cycles
	initial phase = 3'h0;
	// Pins move on the falling edge, clear of the sampling edge
	always @(negedge ref_clk) begin
		phase <= phase + 3'h1;
	end
	assign in_clk = phase < 3'h4;
	assign in_clk_n = !in_clk;
	// Output pair lags the input pair so it follows K within a cycle
	assign out_clk = single | (phase inside {[3'h1:3'h4]});
	assign out_clk_n = single | !(phase inside {[3'h1:3'h4]});
endmodule

// file: dv/testbench.sv
/*
 Self-checking bench of the split-port memory core: bursts, lanes, arbitration.
 Assumes the clock source model and a design array that keeps contents over reset.
*/
`timescale 1ns/100ps
module testbench;
	import spbsc_pkg::*;
	typedef struct {int key; int due;} spbsc_exp_t;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic single = 1'b0;
	logic in_clk, in_clk_n, out_clk, out_clk_n, rd_oe, imp_upd, single_mode;
	logic [2:0] phase;
	logic rd_sel_n = 1'b1;
	logic wr_sel_n = 1'b1;
	logic [1:0] lanes_n = 2'h3;
	logic [ADDR_W-1:0] addr = 18'h00000;
	logic [ADDR_W-1:0] addrs [4];
	logic [DATA_W-1:0] wr_data = 18'h00000;
	logic [DATA_W-1:0] rd_data;
	logic [DATA_W-1:0] mem [int];
	spbsc_exp_t exp_q [$];
	spbsc_exp_t e;
	int tests_run = 0;
	int miscompares = 0;
	int slot = 0;
	int cyc = 0;
	int last_upd = 0;
	int n_upd = 0;
	int wstage, waddr;
	bit prev_r, prev_w;

	always #2 ref_clk = ~ref_clk;

	spbsc_clkgen gen (.ref_clk(ref_clk), .single(single), .in_clk(in_clk), .in_clk_n(in_clk_n),
		.out_clk(out_clk), .out_clk_n(out_clk_n), .phase(phase));
	spbsc_core #(.AW(ADDR_W)) uut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .IN_CLK(in_clk),
		.IN_CLK_N(in_clk_n), .OUT_CLK(out_clk), .OUT_CLK_N(out_clk_n), .READ_PORT_SELECT_N(rd_sel_n),
		.WRITE_PORT_SELECT_N(wr_sel_n), .BYTE_LANE_WRITE_SELECT_N(lanes_n), .ADDR(addr),
		.WR_DATA(wr_data), .RD_DATA(rd_data), .RD_DATA_OE(rd_oe), .IMPEDANCE_UPDATE(imp_upd),
		.SINGLE_CLOCK_MODE(single_mode));

	task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp, input string what);
		check_word({17'h00000, got}, {17'h00000, exp}, what);
	endtask

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic at_phase(input logic [2:0] p);
		int n;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (phase !== p && n < 16);
		if (n >= 16) begin
			miscompares++;
			final_report();
		end
	endtask

	task automatic put(input int k, input logic [DATA_W-1:0] d, input logic [1:0] b_n);
		logic [DATA_W-1:0] m;
		m = mem.exists(k) ? mem[k] : 'x;
		if (!b_n[0]) m[8:0] = d[8:0];
		if (!b_n[1]) m[17:9] = d[17:9];
		mem[k] = m;
	endtask

	// One memory cycle: selects at the K rise, even word then odd word
	task automatic kcycle(input logic r_n, input logic w_n, input logic [ADDR_W-1:0] a, input bit full);
		logic acc_r, acc_w;
		logic [DATA_W-1:0] d0, d1;
		logic [1:0] b0, b1;
		acc_r = !r_n && !prev_r;
		acc_w = !w_n && !prev_w && !acc_r;
		d0 = DATA_W'($urandom());
		d1 = DATA_W'($urandom());
		b0 = full ? 2'h0 : 2'($urandom());
		b1 = full ? 2'h0 : 2'($urandom());
		at_phase(3'h6);
		rd_sel_n = r_n;
		wr_sel_n = w_n;
		addr = a;
		wr_data = d0;
		lanes_n = b0;
		if (wstage != 0) begin
			put(waddr * 4 + (wstage - 1) * 2, d0, b0);
			put(waddr * 4 + (wstage - 1) * 2 + 1, d1, b1);
		end
		wstage = (wstage == 1) ? 2 : 0;
		if (acc_w) begin
			waddr = int'(a);
			wstage = 1;
		end
		if (acc_r) begin
			for (int i = 0; i < 4; i++) exp_q.push_back('{int'(a) * 4 + i, slot + 3 + i});
		end
		prev_r = acc_r;
		prev_w = acc_w;
		at_phase(3'h2);
		rd_sel_n = 1'b1;
		wr_sel_n = 1'b1;
		wr_data = d1;
		lanes_n = b1;
	endtask

	// Kind 0 fills, 1 reads with refused repeats, 2 holds both selects low
	task automatic run(input int kind);
		for (int j = 0; j < 10; j++) begin
			case (kind)
				0: kcycle(1'b1, j >= 8, j % 2 ? addrs[0] : addrs[j / 2], 1'b1);
				1: kcycle(j >= 8, 1'b1, j % 2 ? addrs[3] : addrs[j / 2], 1'b0);
				default: kcycle(j >= 8, j >= 8, j % 2 ? addrs[(j / 2 + 1) % 4] : addrs[j / 2], 1'b0);
			endcase
		end
	endtask

	task automatic do_reset(input logic mode);
		single = mode;
		sys_rst = 1'b1;
		repeat (10) @(negedge ref_clk);
		sys_rst = 1'b0;
		prev_r = 0;
		prev_w = 0;
		wstage = 0;
		repeat (12) @(negedge ref_clk);
		check_bit(single_mode, mode, "strap mode");
	endtask

	// Each sample slot either expects its due word or a floating output
	always @(negedge ref_clk) begin
		if (phase == 3'h7 || phase == 3'h3) begin
			if (exp_q.size() > 0 && exp_q[0].due == slot) begin
				e = exp_q.pop_front();
				check_bit(rd_oe, 1'b1, "read enable");
				check_word(rd_data, mem[e.key], "read word");
			end else begin
				check_bit(rd_oe, 1'b0, "idle enable");
			end
			slot++;
		end
	end

	// Sampled half a cycle after the launching edge
	always @(negedge ref_clk) begin
		cyc++;
		if (sys_rst) begin
			last_upd = 0;
		end else if (imp_upd === 1'b1) begin
			if (last_upd > 0) check_word(DATA_W'(cyc - last_upd), DATA_W'(IMP_PERIOD), "update gap");
			last_upd = cyc;
			n_upd++;
		end
	end

	initial begin
		#200000;
		miscompares++;
		final_report();
	end

	initial begin
		void'($urandom(38));
		foreach (addrs[i]) addrs[i] = {16'($urandom()), 2'(i)};
		for (int m = 0; m < 2; m++) begin
			do_reset(m[0]);
			run(0);
			run(1);
			run(2);
			run(1);
			// Select-free cycles with live data must leave contents alone
			repeat (300) kcycle(1'b1, 1'b1, 18'($urandom()), 1'b0);
			run(1);
			repeat (4) kcycle(1'b1, 1'b1, addrs[0], 1'b0);
		end
		check_bit(n_upd >= 3, 1'b1, "update pulses");
		check_bit(exp_q.size() == 0, 1'b1, "pending reads");
		final_report();
	end
endmodule
